// [rtl/tim_time_base.sv]
// Purpose: up-counting time base of a general purpose timer, AXI4-Lite registers
// Assumes: all inputs synchronous to aclk
// Notes:   one instance per timer; no debug freeze input exists
`timescale 1ns/1ns
`include "tim_consts.svh"

// Overview of operation
// [RQ1] 16-bit counter wraps at reload value
// [RQ2] prescaler divides by two to exponent
// [RQ3] exponent buffered, used from next update
// [RQ4] reload buffered, shadow copy continuous or update
// [RQ5] update on overflow unless disabled, or software
// [RQ6] counter advances on ticks while enabled
// [RQ7] internal enable follows enable bit one cycle
// [RQ8] no debug freeze; counters keep running
// [RQ9] counts zero to reload, wraps, overflows
// [RQ10] update from overflow, generate bit, slave
// [RQ11] update disable suppresses all updates
// [RQ12] update request restarts counter and divider
// [RQ13] request source bit hides generated flag
// [RQ14] update sets flag and refreshes shadows
// [RQ15] update loads exponent and reload shadow
// [RQ16] counter, reload, prescale always accessible
// [RQ17] enabled output channel owns its pin
// [RQ18] second timer remaps channels to port B
// [RQ19] external clock inputs only in external mode
// [RQ20] owned pin driven only by timer
// [RQ21] instances independent, no shared resources
// [RQ22] generate bit self clears, reads zero
// [RQ23] reset clears control bits, flag, counters
module tim_time_base
	import tim_pkg::*;
#(
	parameter bit SECOND_TIMER = 1'b0
) (
	input  wire logic        aclk,          // clock, 10 MHz
	input  wire logic        aresetn,       // sync reset, low
	input  wire logic        ce,            // clock enable
	input  wire logic [7:0]  s_awaddr,      // write address
	input  wire logic        s_awvalid,     // write address valid
	output logic             s_awready,     // write address ready
	input  wire logic [31:0] s_wdata,       // write data
	input  wire logic [3:0]  s_wstrb,       // write strobes
	input  wire logic        s_wvalid,      // write data valid
	output logic             s_wready,      // write data ready
	output logic [1:0]       s_bresp,       // write response
	output logic             s_bvalid,      // write response valid
	input  wire logic        s_bready,      // write response ready
	input  wire logic [7:0]  s_araddr,      // read address
	input  wire logic        s_arvalid,     // read address valid
	output logic             s_arready,     // read address ready
	output logic [31:0]      s_rdata,       // read data
	output logic [1:0]       s_rresp,       // read response
	output logic             s_rvalid,      // read data valid
	input  wire logic        s_rready,      // read data ready
	input  wire logic        ext_clock_in,  // external count clock
	input  wire logic        clock_mask_in, // external clock mask
	input  wire logic        slave_update,  // update request from slave mode
	input  wire logic [3:0]  ch_level,      // channel output levels
	output logic             update_event,  // update event pulse
	output logic             update_flag,   // update flag
	output logic [15:0]      counter_value, // current count
	output logic [3:0]       pa_o,          // port A channel levels
	output logic [3:0]       pa_oe,         // port A drive enables
	output logic [3:0]       pb_o,          // port B channel levels
	output logic [3:0]       pb_oe,         // port B drive enables
	output logic [3:0]       pin_own        // pin taken by timer
);
	// ****************************************
	// bus slave state
	// ****************************************
	logic        aw_got_ff, nxt_aw_got;
	logic        w_got_ff, nxt_w_got;
	logic [7:0]  awaddr_ff, nxt_awaddr;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [3:0]  wstrb_ff, nxt_wstrb;
	logic        bvalid_ff, nxt_bvalid;
	logic [1:0]  bresp_ff, nxt_bresp;
	logic        rvalid_ff, nxt_rvalid;
	logic [1:0]  rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata;
	logic        wr_go;
	logic        rd_go;
	logic        wr_hit;
	logic [31:0] rd_word;
	logic        rd_hit;

	// ****************************************
	// timer state
	// ****************************************
	logic        count_enable_bit_ff, nxt_count_enable_bit;
	logic        count_enable_internal_ff;
	logic        update_disable_ff, nxt_update_disable;
	logic        update_request_source_ff, nxt_update_request_source;
	logic        reload_buffer_enable_ff, nxt_reload_buffer_enable;
	clk_src_e    clk_src_ff, nxt_clk_src;
	logic        update_flag_ff, nxt_update_flag;
	count_t      cnt_ff, nxt_cnt;
	count_t      reload_value_ff, nxt_reload_value;
	count_t      reload_shadow_ff, nxt_reload_shadow;
	exp_t        prescale_exponent_ff, nxt_prescale_exponent;
	logic [3:0]  channel_remap_ff, nxt_channel_remap;
	logic [3:0]  ch_out_ff, nxt_ch_out;
	logic [3:0]  ch_en_ff, nxt_ch_en;
	logic        ext_prev_ff;
	logic        src_pulse;
	logic        adv_tick;
	logic        overflow;
	logic        update_generate;
	logic        update_req;
	logic        upd_fire;
	logic        flag_set;
	logic        flag_clr;
	logic        cnt_wr;

	presc_if pif ();

	// byte lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	// ****************************************
	// AXI4-Lite handshakes
	// ****************************************

	// ready terms, held low while frozen or the response of their own path is pending
	assign s_awready = ce & ~aw_got_ff & ~bvalid_ff;
	assign s_wready  = ce & ~w_got_ff & ~bvalid_ff;
	assign s_arready = ce & ~rvalid_ff;
	assign s_bvalid  = bvalid_ff;
	assign s_bresp   = bresp_ff;
	assign s_rvalid  = rvalid_ff;
	assign s_rresp   = rresp_ff;
	assign s_rdata   = rdata_ff;
	assign wr_go     = aw_got_ff & w_got_ff & ~bvalid_ff;
	assign rd_go     = s_arvalid & s_arready;
	assign wr_hit    = (awaddr_ff[7:5] == 3'b000) && (awaddr_ff[1:0] == 2'b00);

	// read mux over the register map
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		case (s_araddr)
			`OFS_CTRL: begin
				rd_word[`CTRL_RUN]     = count_enable_bit_ff;
				rd_word[`CTRL_UPD_OFF] = update_disable_ff;
				rd_word[`CTRL_UPD_SRC] = update_request_source_ff;
				rd_word[`CTRL_RLD_BUF] = reload_buffer_enable_ff;
				rd_word[`CTRL_EXTCLK] = clk_src_ff;
			end
			// [RQ22] generate bit always reads zero
			`OFS_EVGEN:  rd_word = 32'h0000_0000;
			`OFS_FLAG:   rd_word[`FLAG_UPD] = update_flag_ff;
			// [RQ16] live counter and buffers readable
			`OFS_COUNT:  rd_word[15:0] = cnt_ff;
			`OFS_PRESC:  rd_word[3:0] = prescale_exponent_ff;
			`OFS_RELOAD: rd_word[15:0] = reload_value_ff;
			`OFS_OPTION: rd_word[3:0] = channel_remap_ff;
			`OFS_CHCFG: begin
				rd_word[`CHCFG_OUT_LO +: 4] = ch_out_ff;
				rd_word[`CHCFG_EN_LO +: 4]  = ch_en_ff;
			end
			default:     rd_hit = 1'b0;
		endcase
	end

	// next bus slave state
	always_comb begin
		nxt_aw_got = aw_got_ff;
		nxt_w_got  = w_got_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata  = wdata_ff;
		nxt_wstrb  = wstrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp  = bresp_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rresp  = rresp_ff;
		nxt_rdata  = rdata_ff;
		if (s_awvalid && s_awready) begin
			nxt_aw_got = 1'b1;
			nxt_awaddr = s_awaddr;
		end
		if (s_wvalid && s_wready) begin
			nxt_w_got = 1'b1;
			nxt_wdata = s_wdata;
			nxt_wstrb = s_wstrb;
		end
		if (wr_go) begin
			nxt_aw_got = 1'b0;
			nxt_w_got  = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp  = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bvalid_ff && s_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (rd_go) begin
			nxt_rvalid = 1'b1;
			nxt_rdata  = rd_word;
			nxt_rresp  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_ff && s_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	// register bus slave state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff <= 1'b0;
			w_got_ff  <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff  <= 32'h0000_0000;
			wstrb_ff  <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= `RESP_OKAY;
			rvalid_ff <= 1'b0;
			rresp_ff  <= `RESP_OKAY;
			rdata_ff  <= 32'h0000_0000;
		end else if (ce) begin
			aw_got_ff <= nxt_aw_got;
			w_got_ff  <= nxt_w_got;
			awaddr_ff <= nxt_awaddr;
			wdata_ff  <= nxt_wdata;
			wstrb_ff  <= nxt_wstrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff  <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rresp_ff  <= nxt_rresp;
			rdata_ff  <= nxt_rdata;
		end
	end

	// ****************************************
	// time base
	// ****************************************

	// [RQ22] generate bit is a pulse, never stored
	assign update_generate = wr_go && awaddr_ff == `OFS_EVGEN && wstrb_ff[0] && wdata_ff[`EVGEN_FIRE];
	assign flag_clr        = wr_go && awaddr_ff == `OFS_FLAG && wstrb_ff[0] && wdata_ff[`FLAG_UPD];
	assign cnt_wr          = wr_go && awaddr_ff == `OFS_COUNT;
	// [RQ10] software or slave mode request
	assign update_req      = update_generate | slave_update;
	// [RQ19] external inputs count only in external mode
	assign src_pulse = (clk_src_ff == SRC_EXTERNAL) ? (ext_clock_in & ~ext_prev_ff & clock_mask_in) : 1'b1;
	// [RQ6] prescaler runs only while enabled
	assign pif.advance = count_enable_internal_ff & src_pulse;
	assign adv_tick    = pif.tick;
	// [RQ9] overflow when count meets reload shadow
	assign overflow    = adv_tick && (cnt_ff == reload_shadow_ff);
	// [RQ5] [RQ11] update event gated by disable
	assign upd_fire    = ~update_disable_ff & (overflow | update_req);
	// [RQ13] generated update without flag when source bit set
	assign flag_set    = ~update_disable_ff & (overflow | slave_update | (update_generate & ~update_request_source_ff));
	// [RQ12] request restarts divider
	assign pif.restart = update_req;
	// [RQ15] exponent working copy loads on update
	assign pif.load    = upd_fire;
	assign pif.exp_buf = prescale_exponent_ff;

	// next control, counter and shadow values
	always_comb begin
		nxt_count_enable_bit      = count_enable_bit_ff;
		nxt_update_disable        = update_disable_ff;
		nxt_update_request_source = update_request_source_ff;
		nxt_reload_buffer_enable  = reload_buffer_enable_ff;
		nxt_clk_src               = clk_src_ff;
		nxt_prescale_exponent     = prescale_exponent_ff;
		nxt_reload_value          = reload_value_ff;
		nxt_channel_remap         = channel_remap_ff;
		nxt_ch_out                = ch_out_ff;
		nxt_ch_en                 = ch_en_ff;
		nxt_update_flag           = update_flag_ff;
		nxt_cnt                   = cnt_ff;
		nxt_reload_shadow         = reload_shadow_ff;
		if (wr_go && awaddr_ff == `OFS_CTRL) begin
			if (wstrb_ff[0]) begin
				nxt_count_enable_bit      = wdata_ff[`CTRL_RUN];
				nxt_update_disable        = wdata_ff[`CTRL_UPD_OFF];
				nxt_update_request_source = wdata_ff[`CTRL_UPD_SRC];
				nxt_reload_buffer_enable  = wdata_ff[`CTRL_RLD_BUF];
			end
			if (wstrb_ff[1]) begin
				nxt_clk_src = clk_src_e'(wdata_ff[`CTRL_EXTCLK]);
			end
		end
		// [RQ3] exponent write goes to buffer
		if (wr_go && awaddr_ff == `OFS_PRESC && wstrb_ff[0]) begin
			nxt_prescale_exponent = wdata_ff[3:0];
		end
		// [RQ4] software reaches reload buffer only
		if (wr_go && awaddr_ff == `OFS_RELOAD) begin
			nxt_reload_value = 16'(merge({16'h0000, reload_value_ff}, wdata_ff, wstrb_ff));
		end
		if (wr_go && awaddr_ff == `OFS_OPTION && wstrb_ff[0]) begin
			nxt_channel_remap = wdata_ff[3:0];
		end
		if (wr_go && awaddr_ff == `OFS_CHCFG && wstrb_ff[0]) begin
			nxt_ch_out = wdata_ff[`CHCFG_OUT_LO +: 4];
			nxt_ch_en  = wdata_ff[`CHCFG_EN_LO +: 4];
		end
		// [RQ12] request restart beats write and count
		if (update_req) begin
			nxt_cnt = 16'h0000;
		end else if (cnt_wr) begin
			nxt_cnt = 16'(merge({16'h0000, cnt_ff}, wdata_ff, wstrb_ff));
		end else if (overflow) begin
			nxt_cnt = 16'h0000;
		end else if (adv_tick) begin
			// [RQ1] 16-bit count step
			nxt_cnt = cnt_ff + 16'h0001;
		end
		// [RQ4] [RQ15] shadow copy continuous or at update
		if (!reload_buffer_enable_ff || upd_fire) begin
			nxt_reload_shadow = reload_value_ff;
		end
		// [RQ14] set wins over software clear
		if (flag_clr) begin
			nxt_update_flag = 1'b0;
		end
		if (flag_set) begin
			nxt_update_flag = 1'b1;
		end
	end

	// register timer state; no halt input, so debug never freezes it
	// [RQ8] [RQ21] private state per instance
	always_ff @(posedge aclk) begin
		// [RQ23] reset values
		if (!aresetn) begin
			count_enable_bit_ff      <= 1'b0;
			count_enable_internal_ff <= 1'b0;
			update_disable_ff        <= 1'b0;
			update_request_source_ff <= 1'b0;
			reload_buffer_enable_ff  <= 1'b0;
			clk_src_ff               <= SRC_INTERNAL;
			update_flag_ff           <= 1'b0;
			cnt_ff                   <= `RST_COUNT;
			reload_value_ff          <= `RST_RELOAD;
			reload_shadow_ff         <= `RST_RELOAD;
			prescale_exponent_ff     <= `RST_PRESC;
			channel_remap_ff         <= 4'h0;
			ch_out_ff                <= 4'h0;
			ch_en_ff                 <= 4'h0;
			ext_prev_ff              <= 1'b0;
		end else if (ce) begin
			count_enable_bit_ff      <= nxt_count_enable_bit;
			// [RQ7] internal enable one cycle late
			count_enable_internal_ff <= count_enable_bit_ff;
			update_disable_ff        <= nxt_update_disable;
			update_request_source_ff <= nxt_update_request_source;
			reload_buffer_enable_ff  <= nxt_reload_buffer_enable;
			clk_src_ff               <= nxt_clk_src;
			update_flag_ff           <= nxt_update_flag;
			cnt_ff                   <= nxt_cnt;
			reload_value_ff          <= nxt_reload_value;
			reload_shadow_ff         <= nxt_reload_shadow;
			prescale_exponent_ff     <= nxt_prescale_exponent;
			channel_remap_ff         <= nxt_channel_remap;
			ch_out_ff                <= nxt_ch_out;
			ch_en_ff                 <= nxt_ch_en;
			ext_prev_ff              <= ext_clock_in;
		end
	end

	assign update_event  = upd_fire & ce;
	assign update_flag   = update_flag_ff;
	assign counter_value = cnt_ff;

	// prescaler divider
	tim_prescaler u_presc (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.pif     (pif)
	);

	// [RQ17] [RQ18] [RQ20] pin ownership and routing
	tim_pin_mux #(
		.SECOND_TIMER (SECOND_TIMER)
	) u_pins (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ce       (ce),
		.ch_level (ch_level),
		.ch_out   (ch_out_ff),
		.ch_en    (ch_en_ff),
		.remap    (channel_remap_ff),
		.pa_o     (pa_o),
		.pa_oe    (pa_oe),
		.pb_o     (pb_o),
		.pb_oe    (pb_oe),
		.own      (pin_own)
	);

	// ****************************************
	// checks
	// ****************************************
	a_en_delay: assert property (@(posedge aclk) disable iff (!aresetn) // RQ7
		ce && count_enable_bit_ff |=> count_enable_internal_ff)
		else $error("internal enable not one cycle after enable bit");
	a_count_gated: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
		ce && !count_enable_internal_ff && !update_req && !cnt_wr |=> $stable(cnt_ff))
		else $error("counter moved while disabled");
	a_overflow_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // RQ9
		ce && overflow && !cnt_wr |=> cnt_ff == 16'h0000)
		else $error("counter did not wrap to zero");
	a_flag_on_ovf: assert property (@(posedge aclk) disable iff (!aresetn) // RQ14
		ce && overflow && !update_disable_ff |=> update_flag_ff)
		else $error("overflow update did not set flag");
	a_src_noflag: assert property (@(posedge aclk) disable iff (!aresetn) // RQ13
		ce && update_generate && update_request_source_ff && !overflow && !slave_update
		&& !update_flag_ff |=> !update_flag_ff)
		else $error("generated update set flag with source bit");
	a_dis_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RQ11
		ce && update_disable_ff && reload_buffer_enable_ff |=> $stable(reload_shadow_ff))
		else $error("shadow changed while update disabled");
	a_gen_restart: assert property (@(posedge aclk) disable iff (!aresetn) // RQ12
		ce && update_generate |=> cnt_ff == 16'h0000)
		else $error("generate bit did not restart counter");
	a_gen_reads_0: assert property (@(posedge aclk) disable iff (!aresetn) // RQ22
		rd_go && s_araddr == `OFS_EVGEN |=> s_rdata == 32'h0000_0000)
		else $error("generate bit read back as set");
endmodule : tim_time_base

// [include/tim_consts.svh]
// Purpose: offsets, field positions, reset values of the timer time base
// Assumes: byte addresses on a 32-bit AXI4-Lite bus, one word per register
// Notes:   definitions only
`ifndef TIM_CONSTS_SVH
`define TIM_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_CTRL     8'h00
`define OFS_EVGEN    8'h04
`define OFS_FLAG     8'h08
`define OFS_COUNT    8'h0c
`define OFS_PRESC    8'h10
`define OFS_RELOAD   8'h14
`define OFS_OPTION   8'h18
`define OFS_CHCFG    8'h1c

// ****************************************
// field positions
// ****************************************
`define CTRL_RUN     0
`define CTRL_UPD_OFF 1
`define CTRL_UPD_SRC 2
`define CTRL_RLD_BUF 7
`define CTRL_EXTCLK  8
`define EVGEN_FIRE   0
`define FLAG_UPD     0
`define CHCFG_OUT_LO 0
`define CHCFG_EN_LO  4

// ****************************************
// reset values and answers
// ****************************************
`define RST_COUNT    16'h0000
`define RST_RELOAD   16'hffff
`define RST_PRESC    4'h0
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10

`endif

// [include/tim_pkg.sv]
// Purpose: shared types of the timer time base
// Assumes: constants live in tim_consts.svh
// Notes:   none
package tim_pkg;
	typedef logic [15:0] count_t;
	typedef logic [3:0]  exp_t;
	typedef enum logic {SRC_INTERNAL = 1'b0, SRC_EXTERNAL = 1'b1} clk_src_e;
endpackage : tim_pkg

// [include/presc_if.sv]
// Purpose: carrier between time base control and prescaler
// Assumes: single clock domain
// Notes:   load takes the buffered exponent into the working copy
`timescale 1ns/1ns
interface presc_if;
	import tim_pkg::*;
	logic advance;
	logic restart;
	logic load;
	exp_t exp_buf;
	logic tick;
	modport ctl (output advance, output restart, output load, output exp_buf, input tick);
	modport pre (input advance, input restart, input load, input exp_buf, output tick);
endinterface : presc_if

// [rtl/tim_prescaler.sv]
// Purpose: power-of-two prescaler with a 16-bit divider counter
// Assumes: advance is already gated by the internal count enable
// Notes:   exponent change only lands on load
`timescale 1ns/1ns
module tim_prescaler
	import tim_pkg::*;
(
	input  wire logic aclk,    // clock
	input  wire logic aresetn, // sync reset, low
	input  wire logic ce,      // clock enable
	presc_if.pre      pif      // prescaler control
);
	count_t div_ff;
	count_t nxt_div;
	exp_t   exp_ff;
	exp_t   nxt_exp;
	count_t mask;

	// [RQ2] divide mask and tick at the last divider step
	assign mask     = (16'h0001 << exp_ff) - 16'h0001;
	assign pif.tick = pif.advance & (div_ff == mask);

	// next divider and working exponent
	always_comb begin
		nxt_div = div_ff;
		nxt_exp = exp_ff;
		// [RQ12] divider restart only
		if (pif.restart) begin
			nxt_div = 16'h0000;
		end else if (pif.advance) begin
			nxt_div = pif.tick ? 16'h0000 : div_ff + 16'h0001;
		end
		// [RQ3] exponent taken at update
		if (pif.load) begin
			nxt_exp = pif.exp_buf;
		end
	end

	// register divider state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_ff <= 16'h0000;
			exp_ff <= 4'h0;
		end else if (ce) begin
			div_ff <= nxt_div;
			exp_ff <= nxt_exp;
		end
	end

	a_div_restart: assert property (@(posedge aclk) disable iff (!aresetn) // RQ12
		ce && pif.restart |=> div_ff == 16'h0000)
		else $error("divider not cleared by restart");
	a_tick_ratio: assert property (@(posedge aclk) disable iff (!aresetn) // RQ2
		ce && pif.tick && exp_ff != 4'h0 && !pif.load |=> !pif.tick)
		else $error("prescaler ticked twice in a row above ratio one");
endmodule : tim_prescaler

// [rtl/tim_pin_mux.sv]
// Purpose: channel pin ownership and port A / port B routing
// Assumes: channel levels come from the channel logic outside
// Notes:   remap only acts on the second timer instance
`timescale 1ns/1ns
module tim_pin_mux #(
	parameter bit SECOND_TIMER = 1'b0
) (
	input  wire logic       aclk,     // clock
	input  wire logic       aresetn,  // sync reset, low
	input  wire logic       ce,       // clock enable
	input  wire logic [3:0] ch_level, // channel output levels
	input  wire logic [3:0] ch_out,   // channel set as output
	input  wire logic [3:0] ch_en,    // channel enabled
	input  wire logic [3:0] remap,    // per channel port B select
	output logic      [3:0] pa_o,     // port A pin levels
	output logic      [3:0] pa_oe,    // port A drive enables
	output logic      [3:0] pb_o,     // port B pin levels
	output logic      [3:0] pb_oe,    // port B drive enables
	output logic      [3:0] own       // timer owns pin
);
	logic [3:0] nxt_pa_o, nxt_pa_oe, nxt_pb_o, nxt_pb_oe, nxt_own;

	// per channel routing
	for (genvar i = 0; i < 4; i++) begin : g_ch
		logic sel_b;
		// [RQ18] remap to port B
		assign sel_b = SECOND_TIMER & remap[i];
		// [RQ17] output and enable takes the pin
		assign nxt_own[i] = ch_out[i] & ch_en[i];
		// [RQ20] only timer drives owned pin
		assign nxt_pa_oe[i] = nxt_own[i] & ~sel_b;
		assign nxt_pb_oe[i] = nxt_own[i] & sel_b;
		assign nxt_pa_o[i]  = nxt_pa_oe[i] & ch_level[i];
		assign nxt_pb_o[i]  = nxt_pb_oe[i] & ch_level[i];
	end

	// register pin outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pa_o  <= 4'h0;
			pa_oe <= 4'h0;
			pb_o  <= 4'h0;
			pb_oe <= 4'h0;
			own   <= 4'h0;
		end else if (ce) begin
			pa_o  <= nxt_pa_o;
			pa_oe <= nxt_pa_oe;
			pb_o  <= nxt_pb_o;
			pb_oe <= nxt_pb_oe;
			own   <= nxt_own;
		end
	end

	a_remap_route: assert property (@(posedge aclk) disable iff (!aresetn) // RQ18
		ce && ch_out[0] && ch_en[0] && remap[0] && SECOND_TIMER |=> pb_oe[0] && !pa_oe[0])
		else $error("remapped channel not on port B");
endmodule : tim_pin_mux

// [tb/tb_top.sv]
// Purpose: self-checking bench of the timer time base
// Assumes: byte offsets of the register map, bus answers in a few cycles
// Notes:   one clock, no random stimulus
`timescale 1ns/1ns
module tb_top;
	import tim_pkg::*;
	logic        aclk = 0, rstn = 0, awv = 0, wv = 0, arv = 0, rdy = 1, ue, uf, awr, wrr, bv, arr, rv;
	logic        ec = 0, cm = 0, su = 0;
	logic [3:0]  ws = 4'hf, lv = 4'h6, po, pae, pbe, pao, pbo;
	logic [7:0]  awa = 0, ara = 0;
	logic [31:0] wd = 0, rdd, ue_n;
	logic [1:0]  br, rr;
	count_t      cv, mx;
	int          n_fail = 0, total_checks = 0, i, k;
	logic [7:0]  ra[6] = '{8'h10, 8'h14, 8'h18, 8'h1c, 8'h04, 8'h00};
	logic [31:0] rw[6] = '{32'h5, 32'h1234, 32'h5, 32'hff, 32'h1, 32'h86};
	logic [31:0] rx[6] = '{32'h5, 32'h1234, 32'h5, 32'hff, 32'h0, 32'h86};

	// device under test as second timer, external clock toggling, clock mask low at first
	tim_time_base #(.SECOND_TIMER(1'b1)) dut_u (.aclk(aclk), .aresetn(rstn), .ce(1'b1), .s_awaddr(awa),
		.s_awvalid(awv), .s_awready(awr), .s_wdata(wd), .s_wstrb(ws), .s_wvalid(wv), .s_wready(wrr),
		.s_bresp(br), .s_bvalid(bv), .s_bready(rdy), .s_araddr(ara), .s_arvalid(arv), .s_arready(arr),
		.s_rdata(rdd), .s_rresp(rr), .s_rvalid(rv), .s_rready(rdy), .ext_clock_in(ec), .clock_mask_in(cm),
		.slave_update(su), .ch_level(lv), .update_event(ue), .update_flag(uf), .counter_value(cv),
		.pa_o(pao), .pa_oe(pae), .pb_o(pbo), .pb_oe(pbe), .pin_own(po));

	// clock of 100 ns period
	initial forever #50 aclk = ~aclk;

	// external count clock at half the bus clock
	always @(posedge aclk) ec <= ~ec;

	// ****************
	// shared tasks
	// ****************
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task end_sim;
		$display("checks %0d failed %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	// a wait that ran out ends the run
	task to;
		if (k == 40) begin
			n_fail++;
			end_sim();
		end
	endtask : to

	// bus write, handshakes sampled before each edge
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic ta, tw, b;
		logic [1:0] r;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(negedge aclk);
			ta = awv & awr;
			tw = wv & wrr;
			b = bv;
			r = br;
			@(posedge aclk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			if (b) break;
		end
		to();
		chk(r, e);
	endtask : wr

	// bus read with data and answer compare
	task rd(input logic [7:0] a, input logic [31:0] d);
		logic ta, b;
		logic [1:0] r;
		logic [31:0] q;
		ara <= a;
		arv <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(negedge aclk);
			ta = arv & arr;
			b = rv;
			q = rdd;
			r = rr;
			@(posedge aclk);
			if (ta) arv <= 1'b0;
			if (b) break;
		end
		to();
		chk(q, d);
		chk(r, 2'b00);
	endtask : rd

	// count update pulses and top count over n cycles
	task run(input int n);
		ue_n = 0;
		mx = 0;
		repeat (n) begin
			@(negedge aclk);
			ue_n += ue;
			if (cv > mx) mx = cv;
		end
		@(posedge aclk);
	endtask : run

	// ****************
	// stimulus
	// ****************
	initial begin
		repeat (8) @(posedge aclk);
		rstn <= 1'b1;
		for (i = 0; i < 6; i++) begin
			wr(ra[i], rw[i], 2'b00);
			rd(ra[i], rx[i]);
		end
		chk({po, pae, pbe, pao, pbo}, 20'hfa524);
		rstn <= 1'b0;
		@(posedge aclk);
		rstn <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h0c, 32'h0);
		rd(8'h14, 32'hffff);
		chk({po, pae, pbe, pao, pbo}, 20'h0);
		wr(8'h40, 32'h1, 2'b10);
		wr(8'h14, 32'h3, 2'b00);
		wr(8'h10, 32'h1, 2'b00);
		wr(8'h04, 32'h1, 2'b00);
		rd(8'h08, 32'h1);
		chk(uf, 32'h1);
		wr(8'h08, 32'h1, 2'b00);
		wr(8'h00, 32'h1, 2'b00);
		run(20);
		run(64);
		chk(ue_n, 32'h8);
		chk(mx, 32'h3);
		wr(8'h00, 32'h4, 2'b00);
		wr(8'h08, 32'h1, 2'b00);
		wr(8'h0c, 32'h5, 2'b00);
		rd(8'h0c, 32'h5);
		wr(8'h04, 32'h1, 2'b00);
		chk(cv, 32'h0);
		rd(8'h08, 32'h0);
		su <= 1'b1;
		@(posedge aclk);
		su <= 1'b0;
		rd(8'h08, 32'h1);
		wr(8'h00, 32'h3, 2'b00);
		run(40);
		chk(ue_n, 32'h0);
		wr(8'h00, 32'h100, 2'b00);
		wr(8'h0c, 32'h0, 2'b00);
		wr(8'h00, 32'h101, 2'b00);
		run(40);
		chk(mx, 32'h0);
		cm <= 1'b1;
		run(40);
		chk(mx, 32'h3);
		end_sim();
	end
endmodule : tb_top
